/* src/toc_timer.sv */
module toc_timer
    import toc_pkg::*;
#(
    parameter int unsigned NSRC = NUM_CAP_SRC,
    parameter int unsigned SELW = CAP_SEL_W
) (
    input  wire logic            SYS_CLK,
    input  wire logic            RST,
    input  wire logic            CE,
    input  wire logic [AW-1:0]   SFR_ADDR,
    input  wire logic [DW-1:0]   SFR_WDATA,
    input  wire logic            SFR_WE,
    input  wire logic            SFR_RE,
    output logic      [DW-1:0]   SFR_RDATA,
    input  wire logic            TIMER_IRQ_ENABLE,
    input  wire logic            TICK_LOW,
    input  wire logic            TICK_HIGH,
    input  wire logic [NSRC-1:0] CAPTURE_SOURCES,
    input  wire logic [SELW-1:0] CAPTURE_SOURCE_SELECT,
    output logic                 TIMER_IRQ
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic toc_sel_t decode(input logic [AW-1:0] a);
        toc_sel_t s;
        s = SEL_NONE;
        case (a)
            ADDR_CTRL:   s = SEL_CTRL;
            ADDR_RLD_LO: s = SEL_RLD_LO;
            ADDR_RLD_HI: s = SEL_RLD_HI;
            ADDR_CNT_LO: s = SEL_CNT_LO;
            ADDR_CNT_HI: s = SEL_CNT_HI;
            default:     s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

    toc_ctrl_t         ctrl_q;
    logic [DW-1:0]     count_low_q;
    logic [DW-1:0]     count_high_q;
    logic [DW-1:0]     reload_low_q;
    logic [DW-1:0]     reload_high_q;
    logic [DW-1:0]     rdata_q;
    logic              irq_q;

    toc_sel_t          wsel;
    toc_sel_t          rsel;
    logic              wr_ctrl;
    logic              wr_rld_lo;
    logic              wr_rld_hi;
    logic              wr_cnt_lo;
    logic              wr_cnt_hi;

    assign wsel      = SFR_WE ? decode(SFR_ADDR) : SEL_NONE;
    assign rsel      = decode(SFR_ADDR);
    assign wr_ctrl   = (wsel == SEL_CTRL);
    assign wr_rld_lo = (wsel == SEL_RLD_LO);
    assign wr_rld_hi = (wsel == SEL_RLD_HI);
    assign wr_cnt_lo = (wsel == SEL_CNT_LO);
    assign wr_cnt_hi = (wsel == SEL_CNT_HI);

    // ------------------------------------------------------------
    // Capture event
    // ------------------------------------------------------------
    logic cap_event;
    logic cap_hit;

    toc_capture_edge #(
        .N  (NSRC),
        .SW (SELW)
    ) u_capture (
        .clk     (SYS_CLK),
        .rst     (RST),
        .ce      (CE),
        .src     (CAPTURE_SOURCES),
        .sel     (CAPTURE_SOURCE_SELECT),
        .event_q (cap_event)
    );

    assign cap_hit = cap_event & ctrl_q.capture_enable;

    // ------------------------------------------------------------
    // Count stepping and overflow detection
    // ------------------------------------------------------------
    logic split;
    logic low_step;
    logic high_step;
    logic low_wrap;
    logic high_wrap;
    logic low_reload;

    assign split = ctrl_q.split_enable;

    // Low byte is always running in split mode, gated otherwise
    assign low_step  = TICK_LOW & (split | ctrl_q.run_control);
    assign low_wrap  = low_step & (count_low_q == BYTE_MAX);

    // In 16-bit mode the high byte steps on the low byte's carry
    assign high_step = split ? (TICK_HIGH & ctrl_q.run_control)
                             : low_wrap;
    // Covers both the 8-bit roll and the full 16-bit wrap
    assign high_wrap = high_step & (count_high_q == BYTE_MAX);

    // 16-bit mode reloads the low byte only on the full wrap
    assign low_reload = ~ctrl_q.capture_enable
                      & (split | high_wrap);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            count_low_q <= RST_BYTE;
        end else if (CE) begin
            if (wr_cnt_lo) begin
                count_low_q <= SFR_WDATA;
            end else if (low_step) begin
                if (low_wrap) begin
                    count_low_q <= low_reload ? reload_low_q
                                              : BYTE_ZERO;
                end else begin
                    count_low_q <= count_low_q + BYTE_ONE;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            count_high_q <= RST_BYTE;
        end else if (CE) begin
            if (wr_cnt_hi) begin
                count_high_q <= SFR_WDATA;
            end else if (high_step) begin
                if (high_wrap) begin
                    // Capture mode free-runs: the pair holds captures
                    count_high_q <= ctrl_q.capture_enable ? BYTE_ZERO
                                                          : reload_high_q;
                end else begin
                    count_high_q <= count_high_q + BYTE_ONE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Reload pair: software value or captured count
    // ------------------------------------------------------------
    // A capture in the same cycle as a software write wins, so a
    // timestamp is never lost to a concurrent reload update.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            reload_low_q  <= RST_BYTE;
            reload_high_q <= RST_BYTE;
        end else if (CE) begin
            if (cap_hit) begin
                reload_low_q  <= count_low_q;
                reload_high_q <= count_high_q;
            end else begin
                if (wr_rld_lo) begin
                    reload_low_q <= SFR_WDATA;
                end
                if (wr_rld_hi) begin
                    reload_high_q <= SFR_WDATA;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Control register and sticky flags
    // ------------------------------------------------------------
    logic high_set;
    logic low_set;

    assign high_set = high_wrap | cap_hit;
    assign low_set  = low_wrap;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= RST_CTRL;
        end else if (CE) begin
            if (wr_ctrl) begin
                ctrl_q.low_overflow_irq_enable <= SFR_WDATA[BIT_LIRQEN];
                ctrl_q.capture_enable          <= SFR_WDATA[BIT_CAPEN];
                ctrl_q.split_enable            <= SFR_WDATA[BIT_SPLIT];
                ctrl_q.run_control             <= SFR_WDATA[BIT_RUN];
            end
            // Set beats a simultaneous software clear
            if (high_set) begin
                ctrl_q.high_overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                ctrl_q.high_overflow_flag <= SFR_WDATA[BIT_HFLAG];
            end
            if (low_set) begin
                ctrl_q.low_overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                ctrl_q.low_overflow_flag <= SFR_WDATA[BIT_LFLAG];
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [DW-1:0] ctrl_rd;

    always_comb begin
        ctrl_rd             = BYTE_ZERO;
        ctrl_rd[BIT_HFLAG]  = ctrl_q.high_overflow_flag;
        ctrl_rd[BIT_LFLAG]  = ctrl_q.low_overflow_flag;
        ctrl_rd[BIT_LIRQEN] = ctrl_q.low_overflow_irq_enable;
        ctrl_rd[BIT_CAPEN]  = ctrl_q.capture_enable;
        ctrl_rd[BIT_SPLIT]  = ctrl_q.split_enable;
        ctrl_rd[BIT_RUN]    = ctrl_q.run_control;
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= BYTE_ZERO;
        end else if (CE && SFR_RE) begin
            case (rsel)
                SEL_CTRL:   rdata_q <= ctrl_rd;
                SEL_RLD_LO: rdata_q <= reload_low_q;
                SEL_RLD_HI: rdata_q <= reload_high_q;
                SEL_CNT_LO: rdata_q <= count_low_q;
                SEL_CNT_HI: rdata_q <= count_high_q;
                default:    rdata_q <= BYTE_ZERO;
            endcase
        end
    end

    assign SFR_RDATA = rdata_q;

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    // Level request: stays up until software clears the flags, so
    // the processor cannot miss it while another routine runs.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            irq_q <= 1'b0;
        end else if (CE) begin
            irq_q <= TIMER_IRQ_ENABLE
                   & (ctrl_q.high_overflow_flag
                      | (ctrl_q.low_overflow_irq_enable
                         & ctrl_q.low_overflow_flag));
        end
    end

    assign TIMER_IRQ = irq_q;

endmodule : toc_timer

/* src/toc_pkg.sv */
package toc_pkg;

    // ------------------------------------------------------------
    // Register addresses and field positions
    // ------------------------------------------------------------
    localparam int unsigned AW          = 8;
    localparam int unsigned DW          = 8;
    localparam logic [AW-1:0] ADDR_CTRL   = 8'hC0;
    localparam logic [AW-1:0] ADDR_RLD_LO = 8'hD2;
    localparam logic [AW-1:0] ADDR_RLD_HI = 8'hD3;
    localparam logic [AW-1:0] ADDR_CNT_LO = 8'hD4;
    localparam logic [AW-1:0] ADDR_CNT_HI = 8'hD5;

    localparam int unsigned BIT_HFLAG   = 7;
    localparam int unsigned BIT_LFLAG   = 6;
    localparam int unsigned BIT_LIRQEN  = 5;
    localparam int unsigned BIT_CAPEN   = 4;
    localparam int unsigned BIT_SPLIT   = 3;
    localparam int unsigned BIT_RUN     = 2;

    localparam logic [DW-1:0] BYTE_MAX  = 8'hFF;
    localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DW-1:0] BYTE_ONE  = 8'h01;
    localparam logic [DW-1:0] RST_BYTE  = 8'h00;

    // ------------------------------------------------------------
    // Capture sources
    // ------------------------------------------------------------
    localparam int unsigned NUM_CAP_SRC = 8;
    localparam int unsigned CAP_SEL_W   = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_overflow_irq_enable;
        logic capture_enable;
        logic split_enable;
        logic run_control;
    } toc_ctrl_t;

    localparam toc_ctrl_t RST_CTRL = '0;

    typedef enum logic [5:0] {
        SEL_NONE   = 6'b000001,
        SEL_CTRL   = 6'b000010,
        SEL_RLD_LO = 6'b000100,
        SEL_RLD_HI = 6'b001000,
        SEL_CNT_LO = 6'b010000,
        SEL_CNT_HI = 6'b100000
    } toc_sel_t;

endpackage : toc_pkg

/* src/toc_capture_edge.sv */
module toc_capture_edge
    import toc_pkg::*;
#(
    parameter int unsigned N  = NUM_CAP_SRC,
    parameter int unsigned SW = CAP_SEL_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic [N-1:0]  src,
    input  wire logic [SW-1:0] sel,
    output logic               event_q
);

    // ------------------------------------------------------------
    // Two-stage synchronisers, one per source
    // ------------------------------------------------------------
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;
    logic [N-1:0] fall;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_src
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else if (ce) begin
                    meta_q[gi] <= src[gi];
                    sync_q[gi] <= meta_q[gi];
                    prev_q[gi] <= sync_q[gi];
                end
            end
            // Capture is taken on high-to-low transitions
            assign fall[gi] = prev_q[gi] & ~sync_q[gi];
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_q <= 1'b0;
        end else if (ce) begin
            event_q <= fall[sel];
        end
    end

endmodule : toc_capture_edge

/* sim/toc_timer_asserts.sv */
module toc_timer_asserts
    import toc_pkg::*;
#(
    parameter int unsigned NSRC = NUM_CAP_SRC,
    parameter int unsigned SELW = CAP_SEL_W
) (
    input wire logic            SYS_CLK,
    input wire logic            RST,
    input wire logic            CE,
    input wire logic [AW-1:0]   SFR_ADDR,
    input wire logic [DW-1:0]   SFR_WDATA,
    input wire logic            SFR_WE,
    input wire logic            SFR_RE,
    input wire logic [DW-1:0]   SFR_RDATA,
    input wire logic            TIMER_IRQ_ENABLE,
    input wire logic            TICK_LOW,
    input wire logic            TICK_HIGH,
    input wire logic [NSRC-1:0] CAPTURE_SOURCES,
    input wire logic [SELW-1:0] CAPTURE_SOURCE_SELECT,
    input wire logic            TIMER_IRQ
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    logic rd_ctl;
    logic cnt_rd;
    logic no_tick;
    assign rd_ctl  = CE && SFR_RE && SFR_ADDR == ADDR_CTRL;
    assign cnt_rd  = CE && SFR_RE
                   && SFR_ADDR inside {ADDR_CNT_LO, ADDR_CNT_HI};
    assign no_tick = !TICK_LOW && !TICK_HIGH;

    chk_irq_needs_en: assert property (
        CE && !TIMER_IRQ_ENABLE |=> !TIMER_IRQ)
        else $error("interrupt raised while disabled");
    chk_irq_from_flags: assert property (
        rd_ctl |=> TIMER_IRQ == ($past(TIMER_IRQ_ENABLE)
            & (SFR_RDATA[7] | (SFR_RDATA[5] & SFR_RDATA[6]))))
        else $error("interrupt level disagrees with flags");
    chk_irq_holds: assert property (
        CE && TIMER_IRQ && TIMER_IRQ_ENABLE && !$past(SFR_WE) |=> TIMER_IRQ)
        else $error("interrupt dropped without software action");
    chk_flags_sticky: assert property (
        rd_ctl && !SFR_WE ##1 rd_ctl
        |=> (SFR_RDATA | $past(SFR_RDATA)) == SFR_RDATA)
        else $error("control bit cleared by itself");
    chk_ctrl_wr_rd: assert property (
        CE && SFR_WE && SFR_ADDR == ADDR_CTRL && no_tick ##1 rd_ctl
        |=> SFR_RDATA == ($past(SFR_WDATA, 2) & 8'hFC))
        else $error("control readback differs from write");
    chk_byte_wr_rd: assert property (
        CE && SFR_WE && SFR_ADDR[7:4] == 4'hD
        ##1 CE && SFR_RE && SFR_ADDR == $past(SFR_ADDR)
        |=> SFR_RDATA == $past(SFR_WDATA, 2))
        else $error("byte readback differs from write");
    chk_cnt_stable: assert property (
        cnt_rd && no_tick && !SFR_WE ##1 cnt_rd && SFR_ADDR == $past(SFR_ADDR)
        |=> $stable(SFR_RDATA))
        else $error("count moved without a tick");
    chk_ctrl_low_zero: assert property (
        rd_ctl |=> SFR_RDATA[1:0] == 2'b00)
        else $error("unused control bits read nonzero");
endmodule : toc_timer_asserts

/* sim/toc_timer_bench.sv */
module toc_timer_bench
    import toc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       sys_clk = 1'b0;
    logic       rst     = 1'b1;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic       we      = 1'b0;
    logic       re      = 1'b0;
    logic       irq_en  = 1'b0;
    logic       tick_lo = 1'b0;
    logic       tick_hi = 1'b0;
    logic [7:0] cap_src = 8'hFF;
    logic [2:0] cap_sel = 3'h3;
    logic       ce      = 1'b1;
    logic [7:0] rdata;
    logic       irq;
    int         err_total = 0;
    int         cmp_count = 0;

    always #2 sys_clk = ~sys_clk;

    toc_timer dut (
        .SYS_CLK(sys_clk), .RST(rst), .CE(ce), .SFR_ADDR(addr),
        .SFR_WDATA(wdata), .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rdata),
        .TIMER_IRQ_ENABLE(irq_en), .TICK_LOW(tick_lo), .TICK_HIGH(tick_hi),
        .CAPTURE_SOURCES(cap_src), .CAPTURE_SOURCE_SELECT(cap_sel),
        .TIMER_IRQ(irq));

    // ------------------------------------------------------------
    // Bus and compare helpers, all entered at a falling edge
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        re = 1'b0;
        @(negedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        we = 1'b0;
        re = 1'b1;
        @(negedge sys_clk);
        chk(rdata, e);
    endtask : rd

    // Strobes drop here so ticks never overlap a register access
    task automatic tk(input logic lo, input logic hi, input int n);
        we = 1'b0;
        re = 1'b0;
        tick_lo = lo;
        tick_hi = hi;
        repeat (n) @(negedge sys_clk);
        tick_lo = 1'b0;
        tick_hi = 1'b0;
        @(negedge sys_clk);
    endtask : tk

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_reset();
        rd(8'hC0, 8'h00);
        rd(8'hC0, 8'h00);
        rd(8'hD2, 8'h00);
        rd(8'hD3, 8'h00);
        rd(8'hD5, 8'h00);
        rd(8'hD5, 8'h00);
        rd(8'hD4, 8'h00);
        rd(8'hC7, 8'h00);
    endtask : s_reset

    task automatic s_wrap();
        irq_en = 1'b1;
        wr(8'hD2, 8'h34);
        wr(8'hD3, 8'h12);
        wr(8'hD4, 8'hFF);
        wr(8'hD5, 8'hFF);
        wr(8'hC0, 8'h04);
        rd(8'hC0, 8'h04);
        tk(1'b1, 1'b0, 1);
        rd(8'hD4, 8'h34);
        rd(8'hD5, 8'h12);
        rd(8'hC0, 8'hC4);
        chk({7'h00, irq}, 8'h01);
        tk(1'b1, 1'b0, 1);
        rd(8'hC0, 8'hC4);
        rd(8'hD4, 8'h35);
        wr(8'hC0, 8'h04);
        rd(8'hC0, 8'h04);
        chk({7'h00, irq}, 8'h00);
    endtask : s_wrap

    task automatic s_split();
        wr(8'hC0, 8'h08);
        wr(8'hD2, 8'hF0);
        wr(8'hD4, 8'hFE);
        wr(8'hD5, 8'h07);
        tk(1'b1, 1'b1, 2);
        rd(8'hD4, 8'hF0);
        rd(8'hD5, 8'h07);
        rd(8'hC0, 8'h48);
        chk({7'h00, irq}, 8'h00);
        wr(8'hC0, 8'h68);
        rd(8'hC0, 8'h68);
        chk({7'h00, irq}, 8'h01);
        wr(8'hC0, 8'h0C);
        tk(1'b0, 1'b1, 1);
        rd(8'hD5, 8'h08);
        wr(8'hD5, 8'hFF);
        tk(1'b0, 1'b1, 1);
        rd(8'hD5, 8'h12);
        rd(8'hC0, 8'h8C);
        chk({7'h00, irq}, 8'h01);
    endtask : s_split

    // Nothing may move, count or land while the clock enable is low
    task automatic s_freeze();
        ce = 1'b0;
        wr(8'hD4, 8'h77);
        tk(1'b1, 1'b1, 2);
        ce = 1'b1;
        rd(8'hD4, 8'hF0);
        rd(8'hD5, 8'h12);
        rd(8'hC0, 8'h8C);
    endtask : s_freeze

    task automatic s_capture();
        wr(8'hC0, 8'h10);
        wr(8'hD4, 8'h56);
        rd(8'hD4, 8'h56);
        wr(8'hD5, 8'hAB);
        // Unselected source falls first: no capture may follow
        cap_src = 8'hFB;
        tk(1'b0, 1'b0, 6);
        rd(8'hD2, 8'hF0);
        rd(8'hC0, 8'h10);
        chk({7'h00, irq}, 8'h00);
        cap_sel = 3'h2;
        cap_src = 8'hFF;
        tk(1'b0, 1'b0, 3);
        cap_src = 8'hFB;
        tk(1'b0, 1'b0, 6);
        rd(8'hD2, 8'h56);
        rd(8'hD3, 8'hAB);
        rd(8'hC0, 8'h90);
        chk({7'h00, irq}, 8'h01);
        cap_src = 8'hFF;
    endtask : s_capture

    task automatic s_midreset();
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        rd(8'hD2, 8'h00);
        rd(8'hC0, 8'h00);
        chk({7'h00, irq}, 8'h00);
    endtask : s_midreset

    task automatic summarize();
        $display("mismatches=%0d compares=%0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        s_reset();
        s_wrap();
        s_split();
        s_freeze();
        s_capture();
        s_midreset();
        summarize();
    end

    // Hang guard: the run is a few hundred cycles at most
    initial begin
        #20000;
        err_total++;
        summarize();
    end
endmodule : toc_timer_bench

bind toc_timer toc_timer_asserts #(.NSRC(NSRC), .SELW(SELW)) u_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE),
    .SFR_RDATA(SFR_RDATA), .TIMER_IRQ_ENABLE(TIMER_IRQ_ENABLE),
    .TICK_LOW(TICK_LOW), .TICK_HIGH(TICK_HIGH),
    .CAPTURE_SOURCES(CAPTURE_SOURCES),
    .CAPTURE_SOURCE_SELECT(CAPTURE_SOURCE_SELECT), .TIMER_IRQ(TIMER_IRQ));
